// file: src/mx_exec.sv
/*
  Executor for a subset of an 8-bit core's instructions, with its own
  accumulator, file registers, program counter, stack top, watchdog and flags.
  Assumes the instruction source is on clk_sys and holds instr steady
  while instr_valid is high; a plain register port reaches the state.
*/
module mx_exec
  import mx_exec_pkg::*;
#(
  parameter int CYCLE_CLKS = INSTR_CYCLE_CLKS,
  parameter int STK_DEPTH = STACK_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire mx_instr_s instr,
  input wire logic instr_valid,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic instr_taken,
  output logic busy,
  output logic [PC_W-1:0] pc,
  output logic [7:0] accum,
  output logic zero_flag,
  output logic timeout_flag,
  output logic power_down_flag,
  output logic [7:0] watchdog_counter,
  output logic [7:0] wdt_prescale,
  output logic [PC_W-1:0] return_stack_top
);

  localparam int PTR_W = $clog2(STK_DEPTH);

  typedef enum logic [1:0] {ST_RUN, ST_CALL2, ST_SKIP2} mx_state_e;

  mx_state_e state;
  logic [$clog2(CYCLE_CLKS+1)-1:0] div_cnt;
  logic cyc_en;
  logic [7:0] file_q [FILE_DEPTH];
  logic [7:0] program_latch_high;
  logic [PTR_W-1:0] stk_ptr;
  logic [7:0] fr;
  logic [7:0] res;
  logic to_w;
  logic to_f;
  logic z_upd;
  logic is_call;
  logic is_skip;
  logic is_wdt;
  logic go;
  logic [PC_W-1:0] pc_inc;

  // ----------------------------------------------------------------
  // Instruction cycle divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      cyc_en <= 1'b0;
    end else if (div_cnt == ($bits(div_cnt))'(CYCLE_CLKS - 1)) begin
      div_cnt <= '0;
      cyc_en <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      cyc_en <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Second cycle of a call or a skip leaves whatever is presented untaken
  assign go = cyc_en && instr_valid && (state == ST_RUN);
  assign fr = file_q[instr.f_addr];
  assign pc_inc = pc + PC_ONE;

  always_comb begin
    res = BYTE_ZERO;
    to_w = 1'b0;
    to_f = 1'b0;
    z_upd = 1'b0;
    is_call = 1'b0;
    is_skip = 1'b0;
    is_wdt = 1'b0;
    case (instr.op)
      watchdog_clear_op: begin
        is_wdt = 1'b1;
      end
      call_via_accumulator_op: begin
        is_call = 1'b1;
      end
      complement_file_op: begin
        res = ~fr;
        to_w = !instr.dest;
        to_f = instr.dest;
      end
      clear_file_op: begin
        to_f = 1'b1;
        z_upd = 1'b1;
      end
      clear_accumulator_op: begin
        to_w = 1'b1;
        z_upd = 1'b1;
      end
      decrement_file_op: begin
        res = fr - BYTE_ONE;
        to_w = !instr.dest;
        to_f = instr.dest;
        z_upd = 1'b1;
      end
      decrement_skip_zero_op: begin
        res = fr - BYTE_ONE;
        to_w = !instr.dest;
        to_f = instr.dest;
        is_skip = (res == BYTE_ZERO);
      end
      default: begin
        res = BYTE_ZERO;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencing and program counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RUN;
      busy <= 1'b0;
      instr_taken <= 1'b0;
    end else begin
      instr_taken <= go;
      if (go && is_call) begin
        state <= ST_CALL2;
        busy <= 1'b1;
      end else if (go && is_skip) begin
        state <= ST_SKIP2;
        busy <= 1'b1;
      end else if (cyc_en && state != ST_RUN) begin
        state <= ST_RUN;
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc <= '0;
    end else if (go && is_call) begin
      pc <= {program_latch_high[6:0], accum};
    end else if (go) begin
      pc <= pc_inc;
    end else if (cyc_en && state == ST_SKIP2) begin
      // Discarded slot still consumes an address
      pc <= pc_inc;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      return_stack_top <= '0;
      stk_ptr <= '0;
    end else if (go && is_call) begin
      return_stack_top <= pc_inc;
      stk_ptr <= stk_ptr + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  // Instruction write-back wins over a port write in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      accum <= BYTE_ZERO;
    end else if (go && to_w) begin
      accum <= res;
    end else if (reg_wr && reg_addr == OFS_ACCUM) begin
      accum <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_q[i] <= BYTE_ZERO;
      end
    end else if (go && to_f) begin
      file_q[instr.f_addr] <= res;
    end else if (reg_wr && reg_addr[FILE_WIN_BIT]) begin
      file_q[reg_addr[FADDR_W-1:0]] <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      program_latch_high <= BYTE_ZERO;
    end else if (reg_wr && reg_addr == OFS_LATCH_HI) begin
      program_latch_high <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Flags and watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      zero_flag <= 1'b0;
    end else if (go && z_upd) begin
      zero_flag <= (res == BYTE_ZERO);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdt_prescale <= BYTE_ZERO;
      watchdog_counter <= BYTE_ZERO;
      timeout_flag <= 1'b1;
      power_down_flag <= 1'b1;
    end else if (go && is_wdt) begin
      wdt_prescale <= BYTE_ZERO;
      watchdog_counter <= BYTE_ZERO;
      timeout_flag <= 1'b1;
      power_down_flag <= 1'b1;
    end else if (cyc_en) begin
      wdt_prescale <= wdt_prescale + BYTE_ONE;
      if (wdt_prescale == BYTE_FULL) begin
        watchdog_counter <= watchdog_counter + BYTE_ONE;
        // Overflow is a timeout; core reset is handled elsewhere
        if (watchdog_counter == BYTE_FULL) begin
          timeout_flag <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= BYTE_ZERO;
    end else if (reg_rd) begin
      if (reg_addr[FILE_WIN_BIT]) begin
        reg_rdata <= file_q[reg_addr[FADDR_W-1:0]];
      end else begin
        case (reg_addr)
          OFS_ACCUM: reg_rdata <= accum;
          OFS_STATUS: reg_rdata <= {5'h00, timeout_flag, power_down_flag, zero_flag};
          OFS_PC_LO: reg_rdata <= pc[7:0];
          OFS_PC_HI: reg_rdata <= {1'b0, pc[14:8]};
          OFS_LATCH_HI: reg_rdata <= program_latch_high;
          OFS_WDT: reg_rdata <= watchdog_counter;
          OFS_TOS_LO: reg_rdata <= return_stack_top[7:0];
          OFS_TOS_HI: reg_rdata <= {1'b0, return_stack_top[14:8]};
          OFS_STK_PTR: reg_rdata <= 8'(stk_ptr);
          default: reg_rdata <= BYTE_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_wdt_zeroed: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == watchdog_clear_op |=> watchdog_counter == 8'h00 && wdt_prescale == 8'h00)
    else $error("watchdog not cleared");

  a_wdt_flags_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == watchdog_clear_op |=> timeout_flag && power_down_flag && $stable(zero_flag))
    else $error("watchdog clear flags wrong");

  a_call_push_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == call_via_accumulator_op |=> return_stack_top == $past(pc) + 15'h0001)
    else $error("call return address wrong");

  a_call_target_pc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == call_via_accumulator_op
    |=> pc == {$past(program_latch_high[6:0]), $past(accum)})
    else $error("call target wrong");

  a_call_two_cycles: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == call_via_accumulator_op |=> busy && !go [*4] ##1 !busy)
    else $error("call not two cycles");

  a_call_flags_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == call_via_accumulator_op
    |=> $stable(zero_flag) && $stable(power_down_flag))
    else $error("call changed flags");

  a_complement_file_op_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == complement_file_op && !instr.dest |=> accum == ~$past(fr))
    else $error("complement result wrong");

  a_clear_file_op_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == clear_file_op |=> zero_flag && file_q[$past(instr.f_addr)] == 8'h00)
    else $error("clear file wrong");

  a_clear_accumulator_op_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == clear_accumulator_op |=> zero_flag && accum == 8'h00)
    else $error("clear accumulator wrong");

  a_decrement_file_op_zflag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == decrement_file_op |=> zero_flag == ($past(fr) == 8'h01))
    else $error("decrement zero flag wrong");

  a_decrement_skip_zero_op_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == decrement_skip_zero_op
    |=> $stable(zero_flag) && $stable(power_down_flag))
    else $error("decrement skip touched flags");

  a_skip_taken: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == decrement_skip_zero_op && fr == 8'h01
    |=> busy ##CYCLE_CLKS pc == $past(pc, CYCLE_CLKS + 1) + 15'h0002)
    else $error("skip did not discard");

  a_single_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op != call_via_accumulator_op && !is_skip |=> !busy && pc == $past(pc) + 15'h0001)
    else $error("single cycle advance wrong");

  a_flags_untouched: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && instr.op == complement_file_op |=> $stable(zero_flag) && $stable(timeout_flag))
    else $error("complement touched flags");

endmodule // mx_exec

// file: src/mx_exec_pkg.sv
/*
  Constants, encodings and carriers for the instruction subset executor.
  Assumes a single 100 MHz clock and an instruction source on that clock.
*/
// Behaviour
// - Watchdog clear zeroes the watchdog counter and its prescaler.
// - Watchdog clear sets timeout and power-down flags, nothing else.
// - Call via accumulator pushes program counter plus one as stack top.
// - Call then loads PC low from accumulator, PC high from latch bits 6..0.
// - Call via accumulator takes two cycles, flags untouched.
// - Complement inverts the file register; selector picks accumulator or file.
// - Clear file writes zero to the file register and sets zero flag.
// - Clear accumulator writes zero to the accumulator and sets zero flag.
// - Decrement writes file minus one to selected target, updates zero flag.
// - Decrement-skip writes file minus one to selected target, flags untouched.
// - Zero decrement-skip result discards next instruction, runs a no-operation.
package mx_exec_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int INSTR_CYCLE_NS = 40;
  localparam int INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int PC_W = 15;
  localparam int FADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int STACK_DEPTH = 16;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_FULL = 8'hff;
  localparam logic [PC_W-1:0] PC_ONE = 15'h0001;

  // ----------------------------------------------------------------
  // Register port map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ACCUM = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h01;
  localparam logic [7:0] OFS_PC_LO = 8'h02;
  localparam logic [7:0] OFS_PC_HI = 8'h03;
  localparam logic [7:0] OFS_LATCH_HI = 8'h04;
  localparam logic [7:0] OFS_WDT = 8'h05;
  localparam logic [7:0] OFS_TOS_LO = 8'h06;
  localparam logic [7:0] OFS_TOS_HI = 8'h07;
  localparam logic [7:0] OFS_STK_PTR = 8'h08;
  localparam int FILE_WIN_BIT = 7;
  localparam int ST_Z_BIT = 0;
  localparam int ST_PD_BIT = 1;
  localparam int ST_TO_BIT = 2;

  // ----------------------------------------------------------------
  // Operations and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    no_operation,
    watchdog_clear_op,
    call_via_accumulator_op,
    complement_file_op,
    clear_file_op,
    clear_accumulator_op,
    decrement_file_op,
    decrement_skip_zero_op
  } mx_op_e;

  typedef struct packed {
    mx_op_e op;
    logic [FADDR_W-1:0] f_addr;
    logic dest;
  } mx_instr_s;

endpackage

// file: tb/tb.sv
/*
  Self-checking bench for the instruction subset executor, with a reference model.
  Assumes the package and executor from src/, a 100 MHz clock and four clocks per cycle.
*/
module tb
  import mx_exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  mx_instr_s instr = '0;
  logic instr_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic instr_taken;
  logic busy;
  logic [PC_W-1:0] pc;
  logic [7:0] accum;
  logic zero_flag;
  logic timeout_flag;
  logic power_down_flag;
  logic [7:0] watchdog_counter;
  logic [7:0] wdt_prescale;
  logic [PC_W-1:0] return_stack_top;
  int fail_count = 0;
  int comparisons = 0;
  int acc_m = 0, pc_m = 0, tos_m = 0, latch_m = 0, z_m = 0, stk_m = 0;
  int f_m [128];
  bit chain = 0, prev_busy = 0;
  logic [7:0] rd;

  always #5 clk_sys = ~clk_sys;

  mx_exec #(.CYCLE_CLKS(4), .STK_DEPTH(16)) i_mx_exec (
    .clk_sys(clk_sys), .rst_n(rst_n), .instr(instr), .instr_valid(instr_valid),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr_taken(instr_taken), .busy(busy), .pc(pc),
    .accum(accum), .zero_flag(zero_flag), .timeout_flag(timeout_flag),
    .power_down_flag(power_down_flag), .watchdog_counter(watchdog_counter),
    .wdt_prescale(wdt_prescale), .return_stack_top(return_stack_top)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Held instruction would run again, so drop valid before register traffic
  task automatic stop;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    chain = 0;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic check_file(input int f);
    reg_read({1'b1, 7'(f)}, rd);
    check(16'(rd), 16'(f_m[f]));
  endtask

  task automatic exec(input mx_op_e op, input logic [6:0] f, input logic d);
    int n, r, e_pc;
    bit eb;
    n = 0;
    eb = 0;
    r = 0;
    @(posedge clk_sys);
    instr <= '{op: op, f_addr: f, dest: d};
    instr_valid <= 1'b1;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (instr_taken !== 1'b1 && n < 40);
    // A stalled executor must not slip through as a pass
    check(16'(instr_taken), 16'h0001);
    e_pc = (pc_m + 1) & 32'h7fff;
    case (op)
      clear_accumulator_op: begin acc_m = 0; z_m = 1; end
      clear_file_op: begin f_m[f] = 0; z_m = 1; end
      complement_file_op: r = ~f_m[f] & 32'hff;
      decrement_file_op, decrement_skip_zero_op: r = (f_m[f] - 1) & 32'hff;
      call_via_accumulator_op: begin
        tos_m = e_pc;
        stk_m = (stk_m + 1) & 32'hf;
        e_pc = ((latch_m & 32'h7f) << 8) | acc_m;
        eb = 1;
      end
      default: ;
    endcase
    if (op inside {complement_file_op, decrement_file_op, decrement_skip_zero_op}) begin
      if (d) f_m[f] = r;
      else acc_m = r;
    end
    if (op == decrement_file_op) z_m = (r == 0);
    pc_m = e_pc;
    if (op == decrement_skip_zero_op && r == 0) begin
      eb = 1;
      pc_m = (e_pc + 1) & 32'h7fff;
    end
    check(16'(pc), 16'(e_pc));
    check(16'(accum), 16'(acc_m));
    check(16'(zero_flag), 16'(z_m));
    check(16'({timeout_flag, power_down_flag}), 16'h0003);
    check(16'(return_stack_top), 16'(tos_m));
    check(16'(busy), 16'(eb));
    if (chain) check(16'(n), prev_busy ? 16'h0007 : 16'h0003);
    if (op == watchdog_clear_op) check({watchdog_counter, wdt_prescale}, 16'h0000);
    chain = 1;
    prev_busy = eb;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int f;
    int v;
    foreach (f_m[i]) f_m[i] = 0;
    void'($urandom(32'hc3bd));
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 check(16'({timeout_flag, power_down_flag, zero_flag}), 16'h0006);
    for (int i = 0; i < 8; i++) begin
      f = $urandom % 128;
      v = $urandom % 256;
      reg_write({1'b1, 7'(f)}, 8'(v));
      f_m[f] = v;
    end
    reg_write(8'h85, 8'h01);
    reg_write(8'h86, 8'h01);
    reg_write(8'h87, 8'h06);
    f_m[5] = 1;
    f_m[6] = 1;
    f_m[7] = 6;
    exec(clear_accumulator_op, 7'h00, 1'b0);
    exec(complement_file_op, 7'h07, 1'b0);
    exec(complement_file_op, 7'h07, 1'b1);
    exec(decrement_file_op, 7'h05, 1'b1);
    exec(decrement_file_op, 7'h05, 1'b0);
    exec(decrement_skip_zero_op, 7'h06, 1'b1);
    exec(decrement_skip_zero_op, 7'h07, 1'b0);
    exec(clear_file_op, 7'h07, 1'b0);
    exec(no_operation, 7'h00, 1'b0);
    stop();
    for (int i = 5; i < 8; i++) check_file(i);
    // Bit 7 of the latch must not reach the program counter
    reg_write(8'h04, 8'hc5);
    reg_write(8'h00, 8'h3a);
    latch_m = 8'hc5;
    acc_m = 8'h3a;
    exec(call_via_accumulator_op, 7'h00, 1'b0);
    exec(decrement_skip_zero_op, 7'h06, 1'b0);
    stop();
    // Let the prescaler and counter move before clearing them
    repeat (1300) @(posedge clk_sys);
    exec(watchdog_clear_op, 7'h00, 1'b0);
    for (int i = 0; i < 60; i++) begin
      exec(mx_op_e'($urandom % 8), 7'($urandom % 16), 1'($urandom));
    end
    stop();
    reg_read(8'h01, rd);
    check(16'(rd), 16'({5'h00, 2'b11, 1'(z_m)}));
    reg_read(8'h40, rd);
    check(16'(rd), 16'h0000);
    reg_read(8'h00, rd);
    check(16'(rd), 16'(acc_m));
    reg_read(8'h02, rd);
    check(16'(rd), 16'(pc_m & 32'hff));
    reg_read(8'h03, rd);
    check(16'(rd), 16'(pc_m >> 8));
    reg_read(8'h07, rd);
    check(16'(rd), 16'(tos_m >> 8));
    reg_read(8'h06, rd);
    check(16'(rd), 16'(tos_m & 32'hff));
    reg_read(8'h08, rd);
    check(16'(rd), 16'(stk_m));
    reg_read(8'h04, rd);
    check(16'(rd), 16'(latch_m));
    for (int i = 0; i < 128; i++) check_file(i);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    wrap_up();
  end
endmodule // tb
